// [src/fpsc_cmd.sv]
// power-down, secured otp and security flag command handling
`timescale 1ns/1ps
module fpsc_cmd (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic                     csPin_n,
	input  wire logic                     sclkPin,
	input  wire logic [3:0]               sioPin,
	output logic      [3:0]               sioOut,
	output logic      [3:0]               sioOe,
	input  wire logic                     quadMode,
	input  wire fpsc_pkg::fpsc_event_type ev,
	input  wire logic                     factoryLockStrap,
	input  wire logic                     lockdownStrap,
	input  wire logic                     protModeStrap,
	input  wire logic [3:0]               bpBits,
	input  wire logic                     bpTargetHit,
	input  wire logic                     sectorTargetHit,
	input  wire logic                     sectorUnlockAll,
	output fpsc_pkg::fpsc_status_type     mode,
	output logic      [7:0]               secFlags
);
	import fpsc_pkg::*;

	localparam int ENTRY_WAIT = PDN_ENTRY_CYC;

	logic [2:0]      sclkSync;
	logic [2:0]      csSync;
	logic [3:0]      sioSync0;
	logic [3:0]      sioSync1;
	logic            sclkRise;
	logic            sclkFall;
	logic            csRise;
	logic            csHigh;
	logic [3:0]      bitCnt;
	logic [3:0]      next_bitCnt;
	logic [7:0]      opcode;
	logic [7:0]      next_opcode;
	logic            reading;
	logic            next_reading;
	logic [2:0]      outPos;
	logic [2:0]      next_outPos;
	logic [3:0]      next_sioOut;
	logic [3:0]      next_sioOe;
	fpsc_pd_type     pdState;
	fpsc_pd_type     next_pdState;
	logic [15:0]     pdCnt;
	logic [15:0]     next_pdCnt;
	logic [7:0]      next_secFlags;
	logic            loadNv;
	logic            sectorLockAll;
	logic            next_sectorLockAll;
	fpsc_status_type next_mode;
	logic            cmdDone;
	logic            active;

	// pin synchronisers, third stage for edges
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sclkSync <= 3'h0;
			csSync   <= 3'h7;
			sioSync0 <= 4'h0;
			sioSync1 <= 4'h0;
		end else begin
			sclkSync <= {sclkSync[1:0], sclkPin};
			csSync   <= {csSync[1:0], csPin_n};
			sioSync0 <= sioPin;
			sioSync1 <= sioSync0;
		end
	end

	assign sclkRise = sclkSync[1] & ~sclkSync[2];
	assign sclkFall = ~sclkSync[1] & sclkSync[2];
	assign csRise   = csSync[1] & ~csSync[2];
	assign csHigh   = csSync[1];
	// exactly one opcode byte before deselect
	assign cmdDone  = csRise && (bitCnt == BYTE_BITS);
	assign active   = (pdState == PD_STANDBY);

	always_comb begin
		next_bitCnt        = bitCnt;
		next_opcode        = opcode;
		next_reading       = reading;
		next_outPos        = outPos;
		next_sioOut        = sioOut;
		next_sioOe         = sioOe;
		next_pdState       = pdState;
		next_pdCnt         = pdCnt;
		next_secFlags      = secFlags;
		next_sectorLockAll = sectorLockAll & ~sectorUnlockAll;
		next_mode          = mode;
		if (csHigh) begin
			next_bitCnt  = 4'h0;
			next_reading = 1'b0;
			next_sioOe   = 4'h0;
		end else if (sclkRise) begin
			// serial one bit, quad one nibble per clock
			if (bitCnt < BYTE_BITS) begin
				if (quadMode) begin
					next_opcode = {opcode[3:0], sioSync1};
				end else begin
					next_opcode = {opcode[6:0], sioSync1[0]};
				end
			end
			if (bitCnt < CNT_MAX) begin
				next_bitCnt = bitCnt + (quadMode ? QUAD_STEP : SERIAL_STEP);
			end
			// flag read starts only in standby, not in entry or deep power-down
			if (active && (next_bitCnt == BYTE_BITS) && (bitCnt != BYTE_BITS)
					&& (next_opcode == OPC_READ_FLAGS)) begin
				next_reading = 1'b1;
				next_outPos  = OUT_START;
			end
		end else if (sclkFall && reading) begin
			// flag byte repeats msb first until deselect
			if (quadMode) begin
				next_sioOut = outPos[2] ? secFlags[7:4] : secFlags[3:0];
				next_sioOe  = OE_QUAD;
				next_outPos = outPos ^ NIBBLE_FLIP;
			end else begin
				next_sioOut = {2'b00, secFlags[outPos], 1'b0};
				next_sioOe  = OE_SERIAL;
				next_outPos = outPos - 3'h1;
			end
		end
		case (pdState)
			PD_STANDBY: begin
				if (cmdDone) begin
					case (opcode)
						OPC_DEEP_PD: begin
							next_pdState = PD_ENTRY;
							next_pdCnt   = 16'(PDN_ENTRY_CYC - 1);
						end
						// otp mode entered, main array hidden
						OPC_ENTER_OTP: next_mode.otpMode = 1'b1;
						OPC_EXIT_OTP: next_mode.otpMode = 1'b0;
						OPC_WRITE_EN: next_mode.write_enable_latch = 1'b1;
						OPC_WRITE_FLAGS: begin
							if (mode.write_enable_latch) begin
								next_secFlags[BIT_LOCKDOWN] = 1'b1;
								next_mode.write_enable_latch               = 1'b0;
							end
						end
						OPC_PROT_SEL: begin
							// mode bit only ever goes to one
							if (mode.write_enable_latch) begin
								next_secFlags[BIT_PROT_MODE] = 1'b1;
								next_mode.write_enable_latch                = 1'b0;
							end
						end
						default: next_mode = mode;
					endcase
				end
			end
			PD_ENTRY: begin
				if (pdCnt == 16'h0) begin
					next_pdState = PD_DEEP;
				end else begin
					next_pdCnt = pdCnt - 16'h1;
				end
			end
			PD_DEEP: begin
				if (cmdDone && (opcode == OPC_WAKE)) begin
					next_pdState = PD_STANDBY;
				end
			end
			default: next_pdState = PD_STANDBY;
		endcase
		// erase fail, set wins over clear
		if (ev.eraseFail) begin
			next_secFlags[BIT_ERASE_FAIL] = 1'b1;
		end else if (ev.eraseOk) begin
			next_secFlags[BIT_ERASE_FAIL] = 1'b0;
		end
		// program fail, set wins over clear
		if (ev.progFail) begin
			next_secFlags[BIT_PROG_FAIL] = 1'b1;
		end else if (ev.progOk) begin
			next_secFlags[BIT_PROG_FAIL] = 1'b0;
		end
		if (ev.eraseSusp) begin
			next_secFlags[BIT_ERASE_SUSP] = 1'b1;
		end else if (ev.eraseResume) begin
			next_secFlags[BIT_ERASE_SUSP] = 1'b0;
		end
		if (ev.progSusp) begin
			next_secFlags[BIT_PROG_SUSP] = 1'b1;
		end else if (ev.progResume) begin
			next_secFlags[BIT_PROG_SUSP] = 1'b0;
		end
		// stored bits loaded once after reset
		if (loadNv) begin
			next_secFlags[BIT_FACTORY]   = factoryLockStrap;
			next_secFlags[BIT_LOCKDOWN]  = lockdownStrap;
			next_secFlags[BIT_PROT_MODE] = protModeStrap;
		end
		next_secFlags[BIT_RSVD] = 1'b0;
		next_mode.deepPd      = (next_pdState == PD_DEEP);
		// otp routing, writes only if not locked
		next_mode.otpWritable = next_mode.otpMode & ~next_secFlags[BIT_LOCKDOWN];
		next_mode.mainArrayEn = ~next_mode.otpMode & (next_pdState == PD_STANDBY);
		// sector commands only in mode one
		next_mode.sectorCmdEn = next_secFlags[BIT_PROT_MODE];
		// one protection scheme at a time
		if (next_secFlags[BIT_PROT_MODE]) begin
			next_mode.writeProtect = next_sectorLockAll | sectorTargetHit;
		end else begin
			next_mode.writeProtect = (bpBits != 4'h0) & bpTargetHit;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bitCnt        <= 4'h0;
			opcode        <= 8'h00;
			reading       <= 1'b0;
			outPos        <= OUT_START;
			sioOut        <= 4'h0;
			sioOe         <= 4'h0;
			pdState       <= PD_STANDBY;
			pdCnt         <= 16'h0;
			secFlags      <= FLAGS_RESET;
			loadNv        <= 1'b1;
			sectorLockAll <= 1'b1;
			mode          <= '0;
		end else begin
			bitCnt        <= next_bitCnt;
			opcode        <= next_opcode;
			reading       <= next_reading;
			outPos        <= next_outPos;
			sioOut        <= next_sioOut;
			sioOe         <= next_sioOe;
			pdState       <= next_pdState;
			pdCnt         <= next_pdCnt;
			secFlags      <= next_secFlags;
			loadNv        <= 1'b0;
			sectorLockAll <= next_sectorLockAll;
			mode          <= next_mode;
		end
	end

	property p_entry_delay;
		@(posedge clk) disable iff (!rst_n)
		$rose(pdState == PD_ENTRY) |-> ##ENTRY_WAIT (pdState == PD_DEEP);
	endproperty
	a_entry_delay: assert property (p_entry_delay) else $error("deep entry delay wrong");

	property p_deep_ignores;
		@(posedge clk) disable iff (!rst_n)
		(pdState == PD_DEEP) |=> $stable(mode.otpMode) && $stable(secFlags[BIT_LOCKDOWN]);
	endproperty
	a_deep_ignores: assert property (p_deep_ignores) else $error("command acted in deep");

	property p_wake;
		@(posedge clk) disable iff (!rst_n)
		(pdState == PD_DEEP) && cmdDone && (opcode == OPC_WAKE) |=> (pdState == PD_STANDBY) && !mode.deepPd;
	endproperty
	a_wake: assert property (p_wake) else $error("wake not taken");

	property p_off_boundary;
		@(posedge clk) disable iff (!rst_n)
		csRise && (bitCnt != BYTE_BITS) && (pdState != PD_ENTRY)
			|=> $stable(mode.otpMode) && $stable(pdState) && $stable(secFlags[BIT_LOCKDOWN]);
	endproperty
	a_off_boundary: assert property (p_off_boundary) else $error("off-boundary command ran");

	property p_need_wel;
		@(posedge clk) disable iff (!rst_n)
		cmdDone && !mode.write_enable_latch && !loadNv |=> $stable(secFlags[BIT_LOCKDOWN]) && $stable(secFlags[BIT_PROT_MODE]);
	endproperty
	a_need_wel: assert property (p_need_wel) else $error("flag changed without latch");

	property p_locked_otp;
		@(posedge clk) disable iff (!rst_n)
		secFlags[BIT_LOCKDOWN] && !loadNv |=> secFlags[BIT_LOCKDOWN] && !mode.otpWritable;
	endproperty
	a_locked_otp: assert property (p_locked_otp) else $error("locked otp writable");

	property p_prot_sticky;
		@(posedge clk) disable iff (!rst_n)
		secFlags[BIT_PROT_MODE] && !loadNv |=> secFlags[BIT_PROT_MODE] ##1 mode.sectorCmdEn;
	endproperty
	a_prot_sticky: assert property (p_prot_sticky) else $error("mode bit returned");

	property p_read_drive;
		@(posedge clk) disable iff (!rst_n)
		reading && sclkFall && !csHigh && !quadMode |=> sioOe[1] && (sioOut[1] == secFlags[$past(outPos)]);
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("flag bit not driven");

	property p_erase_fail;
		@(posedge clk) disable iff (!rst_n)
		ev.eraseFail |=> secFlags[BIT_ERASE_FAIL];
	endproperty
	a_erase_fail: assert property (p_erase_fail) else $error("erase fail lost");

	property p_rsvd_zero;
		@(posedge clk) disable iff (!rst_n)
		!secFlags[BIT_RSVD];
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");
endmodule

// [src/fpsc_pkg.sv]
// constants and types for the power and security command block
package fpsc_pkg;
	localparam int CLK_MHZ       = 50;
	localparam int PDN_ENTRY_NS  = 3000;
	localparam int PDN_ENTRY_CYC = (PDN_ENTRY_NS * CLK_MHZ + 999) / 1000;

	localparam logic [7:0] OPC_DEEP_PD     = 8'hA1;
	localparam logic [7:0] OPC_WAKE        = 8'hA2;
	localparam logic [7:0] OPC_ENTER_OTP   = 8'hA3;
	localparam logic [7:0] OPC_EXIT_OTP    = 8'hA4;
	localparam logic [7:0] OPC_READ_FLAGS  = 8'hA5;
	localparam logic [7:0] OPC_WRITE_FLAGS = 8'hA6;
	localparam logic [7:0] OPC_WRITE_EN    = 8'hA7;
	localparam logic [7:0] OPC_PROT_SEL    = 8'hA8;

	localparam int BIT_PROT_MODE  = 7;
	localparam int BIT_ERASE_FAIL = 6;
	localparam int BIT_PROG_FAIL  = 5;
	localparam int BIT_RSVD       = 4;
	localparam int BIT_ERASE_SUSP = 3;
	localparam int BIT_PROG_SUSP  = 2;
	localparam int BIT_LOCKDOWN   = 1;
	localparam int BIT_FACTORY    = 0;
	localparam logic [7:0] FLAGS_RESET = 8'h00;

	localparam logic [3:0] BYTE_BITS   = 4'h8;
	localparam logic [3:0] CNT_MAX     = 4'hC;
	localparam logic [3:0] SERIAL_STEP = 4'h1;
	localparam logic [3:0] QUAD_STEP   = 4'h4;
	localparam logic [2:0] OUT_START   = 3'h7;
	localparam logic [2:0] NIBBLE_FLIP = 3'h4;
	localparam logic [3:0] OE_SERIAL   = 4'h2;
	localparam logic [3:0] OE_QUAD     = 4'hF;

	typedef enum logic [1:0] {
		PD_STANDBY = 2'b00,
		PD_ENTRY   = 2'b01,
		PD_DEEP    = 2'b11
	} fpsc_pd_type;

	typedef struct packed {
		logic eraseFail;
		logic eraseOk;
		logic progFail;
		logic progOk;
		logic eraseSusp;
		logic eraseResume;
		logic progSusp;
		logic progResume;
	} fpsc_event_type;

	typedef struct packed {
		logic deepPd;
		logic otpMode;
		logic otpWritable;
		logic mainArrayEn;
		logic sectorCmdEn;
		logic writeProtect;
		logic write_enable_latch;
	} fpsc_status_type;
endpackage

// [tb/fpsc_host.sv]
// host model driving the serial command pins
`timescale 1ns/1ps
module fpsc_host (
	input  wire logic       quadMode,
	input  wire logic [3:0] sioOut,
	input  wire logic [3:0] sioOe,
	output logic            csPin_n,
	output logic            sclkPin,
	output logic      [3:0] sioPin
);
	logic [3:0] seenOe;
	initial begin
		csPin_n = 1'b1;
		sclkPin = 1'b0;
		sioPin  = 4'h5;
		seenOe  = 4'h0;
	end
	task automatic send(input logic [7:0] op, input int nClk);
		logic [7:0] sh;
		sh = op;
		csPin_n = 1'b0;
		for (int i = 0; i < nClk; i++) begin
			sclkPin = 1'b0;
			// upper lines toggle in serial mode
			sioPin = quadMode ? sh[7:4] : {~sioPin[3:1], sh[7]};
			sh = quadMode ? {sh[3:0], 4'h0} : {sh[6:0], 1'b0};
			#80 sclkPin = 1'b1;
			#80;
		end
		sclkPin = 1'b0;
		#80 csPin_n = 1'b1;
		sioPin = ~sioPin;
		#160;
	endtask
	// opcode then two repeats of the flag byte
	task automatic read(output logic [7:0] val);
		logic [7:0] sh;
		int         nOp;
		sh = fpsc_pkg::OPC_READ_FLAGS;
		nOp = quadMode ? 2 : 8;
		csPin_n = 1'b0;
		for (int i = 0; i < 3 * nOp; i++) begin
			sclkPin = 1'b0;
			sioPin = quadMode ? sh[7:4] : {~sioPin[3:1], sh[7]};
			sh = quadMode ? {sh[3:0], 4'h0} : {sh[6:0], 1'b0};
			#80 sclkPin = 1'b1;
			#70;
			if (i >= nOp) begin
				val    = quadMode ? {val[3:0], sioOut} : {val[6:0], sioOut[1]};
				seenOe = sioOe;
			end
			#10;
		end
		sclkPin = 1'b0;
		#80 csPin_n = 1'b1;
		sioPin = ~sioPin;
		#160;
	endtask
endmodule

// [tb/testbench.sv]
// self-checking bench for the power and security command block
`timescale 1ns/1ps
module testbench;
	import fpsc_pkg::*;
	localparam logic [7:0] FLAG_BIT [4] = '{8'h40, 8'h20, 8'h08, 8'h04};
	logic            clk = 1'b0;
	logic            rst_n = 1'b0;
	logic            quadMode = 1'b0;
	logic            csPin_n, sclkPin;
	logic      [3:0] sioPin, sioOut, sioOe;
	logic      [3:0] bpBits = 4'h0;
	fpsc_event_type  ev = '0;
	logic            factoryLockStrap = 1'b0, lockdownStrap = 1'b0, protModeStrap = 1'b0;
	logic            bpTargetHit = 1'b0, sectorTargetHit = 1'b0, sectorUnlockAll = 1'b0;
	fpsc_status_type mode;
	logic      [7:0] secFlags, rd;
	int              errors = 0, n_checks = 0, cycles = 0;

	always #10 clk = ~clk;

	fpsc_cmd u_fpsc_cmd (.clk(clk), .rst_n(rst_n), .csPin_n(csPin_n), .sclkPin(sclkPin),
		.sioPin(sioPin), .sioOut(sioOut), .sioOe(sioOe), .quadMode(quadMode), .ev(ev),
		.factoryLockStrap(factoryLockStrap), .lockdownStrap(lockdownStrap),
		.protModeStrap(protModeStrap), .bpBits(bpBits), .bpTargetHit(bpTargetHit),
		.sectorTargetHit(sectorTargetHit), .sectorUnlockAll(sectorUnlockAll),
		.mode(mode), .secFlags(secFlags));
	fpsc_host u_fpsc_host (.quadMode(quadMode), .sioOut(sioOut), .sioOe(sioOe), .csPin_n(csPin_n),
		.sclkPin(sclkPin), .sioPin(sioPin));

	task automatic conclude();
		if (errors == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk({7'h0, got}, {7'h0, exp});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic do_reset();
		rst_n = 1'b0;
		tick(6);
		rst_n = 1'b1;
		tick(3);
	endtask
	task automatic pulse(input int b);
		ev = fpsc_event_type'(8'h01 << b);
		tick(1);
		ev = '0;
		tick(2);
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			errors++;
			conclude();
		end
	end

	initial begin
		do_reset();
		chk(secFlags, FLAGS_RESET);
		chk1(mode.mainArrayEn, 1'b1);
		u_fpsc_host.read(rd);
		chk(rd, 8'h00);
		chk({4'h0, u_fpsc_host.seenOe}, {4'h0, OE_SERIAL});
		chk({4'h0, sioOe}, 8'h00);
		for (int k = 0; k < 4; k++) begin
			pulse(7 - 2 * k);
			chk(secFlags, FLAG_BIT[k]);
			u_fpsc_host.read(rd);
			chk(rd, FLAG_BIT[k]);
			pulse(6 - 2 * k);
			chk(secFlags, 8'h00);
		end
		ev = fpsc_event_type'(8'hC0);
		tick(1);
		ev = '0;
		tick(2);
		chk(secFlags, 8'h40);
		pulse(6);
		chk(secFlags, 8'h00);
		u_fpsc_host.send(OPC_WRITE_FLAGS, 8);
		chk(secFlags, 8'h00);
		u_fpsc_host.send(OPC_WRITE_EN, 8);
		chk1(mode.write_enable_latch, 1'b1);
		u_fpsc_host.send(OPC_WRITE_FLAGS, 9);
		chk(secFlags, 8'h00);
		u_fpsc_host.send(OPC_ENTER_OTP, 8);
		chk1(mode.otpMode, 1'b1);
		chk1(mode.mainArrayEn, 1'b0);
		chk1(mode.otpWritable, 1'b1);
		u_fpsc_host.send(OPC_WRITE_FLAGS, 8);
		chk(secFlags, 8'h02);
		chk1(mode.otpWritable, 1'b0);
		u_fpsc_host.send(OPC_WRITE_EN, 8);
		u_fpsc_host.send(OPC_WRITE_FLAGS, 8);
		chk(secFlags, 8'h02);
		u_fpsc_host.send(OPC_EXIT_OTP, 8);
		chk1(mode.otpMode, 1'b0);
		chk1(mode.mainArrayEn, 1'b1);
		u_fpsc_host.send(OPC_DEEP_PD, 7);
		tick(200);
		chk1(mode.deepPd, 1'b0);
		u_fpsc_host.send(OPC_DEEP_PD, 8);
		tick(100);
		chk1(mode.deepPd, 1'b0);
		tick(60);
		chk1(mode.deepPd, 1'b1);
		u_fpsc_host.send(OPC_ENTER_OTP, 8);
		chk1(mode.otpMode, 1'b0);
		u_fpsc_host.send(OPC_WAKE, 8);
		chk1(mode.deepPd, 1'b0);
		u_fpsc_host.send(OPC_DEEP_PD, 8);
		tick(170);
		factoryLockStrap = 1'b1;
		lockdownStrap = 1'b1;
		do_reset();
		chk1(mode.deepPd, 1'b0);
		chk(secFlags, 8'h03);
		bpBits = 4'h3;
		bpTargetHit = 1'b1;
		tick(2);
		chk1(mode.writeProtect, 1'b1);
		bpBits = 4'h0;
		tick(2);
		chk1(mode.writeProtect, 1'b0);
		quadMode = 1'b1;
		u_fpsc_host.send(OPC_WRITE_EN, 2);
		u_fpsc_host.send(OPC_PROT_SEL, 2);
		chk(secFlags, 8'h83);
		chk1(mode.sectorCmdEn, 1'b1);
		u_fpsc_host.read(rd);
		chk(rd, 8'h83);
		chk({4'h0, u_fpsc_host.seenOe}, {4'h0, OE_QUAD});
		chk1(mode.writeProtect, 1'b1);
		bpBits = 4'h3;
		sectorUnlockAll = 1'b1;
		tick(1);
		sectorUnlockAll = 1'b0;
		tick(2);
		chk1(mode.writeProtect, 1'b0);
		sectorTargetHit = 1'b1;
		tick(2);
		chk1(mode.writeProtect, 1'b1);
		quadMode = 1'b0;
		tick(1);
		u_fpsc_host.read(rd);
		chk(rd, 8'h83);
		conclude();
	end
endmodule
